// file: verilog/lrp_power_ctrl.sv
// Reset state, power-down and booster/display sequencing for the panel driver.
// Assumes deserialised bytes from the host path; memory lives elsewhere and is never cleared here.
module lrp_power_ctrl (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic byte_valid_i,
  input wire logic cmd_sel_n_i,
  input wire logic [7:0] byte_i,
  input wire logic sleep_in_i,
  input wire logic sleep_out_i,
  input wire logic panel_on_cmd_i,
  input wire logic panel_off_cmd_i,
  input wire logic supply_ready_i,
  input wire logic lock_maker_defaults_i,
  input wire logic calib_enter_i,
  input wire logic otp_prog_req_i,
  output logic transfer_end_o,
  output logic soft_clear_o,
  output logic iface_drive_en_o,
  output logic power_down_o,
  output logic pump_enable_o,
  output logic supply_out_en_o,
  output logic panel_drive_o,
  output logic status_ready_o,
  output logic pump_flag_o,
  output logic panel_flag_o,
  output logic polarity_invert_o,
  output logic tear_pulse_en_o,
  output logic low_colour_o,
  output logic full_panel_mode_o,
  output logic [9:0] orient_flags_o,
  output logic temp_comp_frame_rate_en_o,
  output logic temp_comp_voltage_en_o,
  output logic [7:0] column_window_start_o,
  output logic [7:0] column_window_end_o,
  output logic [7:0] row_window_start_o,
  output logic [7:0] row_window_end_o,
  output logic [7:0] partial_area_start_o,
  output logic [7:0] partial_area_end_o,
  output logic [7:0] top_fixed_rows_o,
  output logic [7:0] bottom_fixed_rows_o,
  output logic [7:0] scroll_height_o,
  output logic [7:0] scroll_entry_point_o,
  output logic [2:0] pixel_format_o,
  output logic use_maker_defaults_o,
  output logic calibration_flag_o,
  output logic otp_prog_voltage_en_o,
  output logic [2:0] otp_row_select_o
);
  import lrp_pkg::*;

  lrp_cmd_if cmd ();
  lrp_decode u_dec (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .byte_valid_i(byte_valid_i),
    .cmd_sel_n_i(cmd_sel_n_i),
    .byte_i(byte_i),
    .cmd(cmd)
  );

  // Soft clear reuses the same reset values as the pin, one cycle after decode
  logic clr;
  // Clears registers only; no display memory here and no busy window after it
  assign clr = cmd.soft_clear;
  logic [1:0] rdy_sync;
  lrp_pwr_e state;
  logic [2:0] stable_cnt;
  logic ready;
  assign ready = rdy_sync[1];

  // Analog ready flag comes from another domain
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) rdy_sync <= 2'b00;
    else rdy_sync <= {rdy_sync[0], supply_ready_i};
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      transfer_end_o <= 1'b0;
      soft_clear_o <= 1'b0;
    end else begin
      transfer_end_o <= cmd.nop;
      soft_clear_o <= clr;
    end
  end

  // Stored flags; power-down never changes them
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      pump_flag_o <= 1'b1;
      panel_flag_o <= 1'b1;
    end else if (clr) begin
      pump_flag_o <= 1'b1;
      panel_flag_o <= 1'b1;
    end else begin
      if (cmd.pump_off) pump_flag_o <= 1'b0;
      else if (cmd.pump_on) pump_flag_o <= 1'b1;
      if (panel_off_cmd_i) panel_flag_o <= 1'b0;
      else if (panel_on_cmd_i) panel_flag_o <= 1'b1;
    end
  end

  // Power state: down, booster ramping, running
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      state <= LRP_PWR_DOWN;
    end else if (clr || sleep_in_i) begin
      state <= LRP_PWR_DOWN;
    end else begin
      case (state)
        LRP_PWR_DOWN: if (sleep_out_i) state <= LRP_PWR_RAMP;
        LRP_PWR_RAMP: if (pump_flag_o && ready) state <= LRP_PWR_RUN;
        LRP_PWR_RUN: if (!(pump_flag_o && ready)) state <= LRP_PWR_RAMP;
        default: state <= LRP_PWR_DOWN;
      endcase
    end
  end

  // Debounce ready so a glitch does not light the panel
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) stable_cnt <= 3'h0;
    else if (state != LRP_PWR_RUN || !ready) stable_cnt <= 3'h0;
    else if (stable_cnt != 3'(LRP_STABLE_CYCLES)) stable_cnt <= stable_cnt + 3'h1;
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      power_down_o <= 1'b1;
      pump_enable_o <= 1'b0;
      supply_out_en_o <= 1'b0;
      panel_drive_o <= 1'b0;
      status_ready_o <= 1'b0;
      iface_drive_en_o <= 1'b0;
    end else begin
      power_down_o <= (state == LRP_PWR_DOWN);
      pump_enable_o <= (state != LRP_PWR_DOWN) && pump_flag_o && !clr;
      supply_out_en_o <= (state != LRP_PWR_DOWN) && pump_flag_o && !clr;
      panel_drive_o <= (state == LRP_PWR_RUN) && panel_flag_o && !clr &&
        stable_cnt == 3'(LRP_STABLE_CYCLES);
      status_ready_o <= pump_flag_o && ready;
      iface_drive_en_o <= 1'b0;
    end
  end

  // Command register defaults; other writers are outside this slice
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      polarity_invert_o <= 1'b0;
      tear_pulse_en_o <= 1'b0;
      low_colour_o <= 1'b0;
      full_panel_mode_o <= 1'b1;
      orient_flags_o <= 10'h000;
      temp_comp_frame_rate_en_o <= 1'b1;
      temp_comp_voltage_en_o <= 1'b1;
      column_window_start_o <= LRP_WIN_START_RST;
      column_window_end_o <= LRP_WIN_END_RST;
      row_window_start_o <= LRP_WIN_START_RST;
      row_window_end_o <= LRP_WIN_END_RST;
      partial_area_start_o <= LRP_PART_START_RST;
      partial_area_end_o <= LRP_PART_END_RST;
      top_fixed_rows_o <= LRP_FIXED_RST;
      bottom_fixed_rows_o <= LRP_FIXED_RST;
      scroll_height_o <= LRP_SCROLL_RST;
      scroll_entry_point_o <= LRP_SEP_RST;
      pixel_format_o <= LRP_PIXFMT_RST;
    end else if (clr) begin
      polarity_invert_o <= 1'b0;
      tear_pulse_en_o <= 1'b0;
      low_colour_o <= 1'b0;
      full_panel_mode_o <= 1'b1;
      orient_flags_o <= 10'h000;
      temp_comp_frame_rate_en_o <= 1'b1;
      temp_comp_voltage_en_o <= 1'b1;
      column_window_start_o <= LRP_WIN_START_RST;
      column_window_end_o <= LRP_WIN_END_RST;
      row_window_start_o <= LRP_WIN_START_RST;
      row_window_end_o <= LRP_WIN_END_RST;
      partial_area_start_o <= LRP_PART_START_RST;
      partial_area_end_o <= LRP_PART_END_RST;
      top_fixed_rows_o <= LRP_FIXED_RST;
      bottom_fixed_rows_o <= LRP_FIXED_RST;
      scroll_height_o <= LRP_SCROLL_RST;
      scroll_entry_point_o <= LRP_SEP_RST;
      pixel_format_o <= LRP_PIXFMT_RST;
    end
  end

  // Maker defaults and calibration control
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      use_maker_defaults_o <= 1'b1;
      calibration_flag_o <= 1'b0;
      otp_prog_voltage_en_o <= 1'b0;
      otp_row_select_o <= LRP_OTP_ROW_RST;
    end else if (clr) begin
      use_maker_defaults_o <= 1'b1;
      calibration_flag_o <= 1'b0;
      otp_prog_voltage_en_o <= 1'b0;
      otp_row_select_o <= LRP_OTP_ROW_RST;
    end else begin
      if (lock_maker_defaults_i) use_maker_defaults_o <= 1'b1;
      if (calib_enter_i && !lock_maker_defaults_i) calibration_flag_o <= 1'b1;
      otp_prog_voltage_en_o <= otp_prog_req_i && calibration_flag_o;
    end
  end

  AST_DOWN_NO_PUMP: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    power_down_o |-> !pump_enable_o && !panel_drive_o)
    else $error("power-down with booster or panel active");
  // Flags checked one cycle earlier so a booster-off right behind is legal
  AST_SOFT_RESET: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    cmd.soft_clear |=> (panel_flag_o && pixel_format_o == LRP_PIXFMT_RST &&
      scroll_height_o == LRP_SCROLL_RST) ##1 power_down_o)
    else $error("soft reset state wrong");
  AST_PANEL_NEEDS_READY: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    panel_drive_o |-> $past(ready, 2))
    else $error("panel on without stable supply");
  AST_STATUS_BIT: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    status_ready_o == $past(pump_flag_o && ready))
    else $error("ready status mismatch");
  AST_PUMP_OFF: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    cmd.pump_off |=> !pump_flag_o ##1 !supply_out_en_o)
    else $error("booster-off not applied");
  AST_PUMP_ON_AWAKE: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (cmd.pump_on && state != LRP_PWR_DOWN && !sleep_in_i) |=> ##1 pump_enable_o)
    else $error("booster-on ignored while awake");
  AST_CAL_LOCK: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (lock_maker_defaults_i && !calibration_flag_o) |=> !calibration_flag_o)
    else $error("calibration entered while locked");
  AST_IFACE_IN: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    !iface_drive_en_o) else $error("interface pins driven");
  AST_NOP_END: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    cmd.nop |=> transfer_end_o && $stable(pump_flag_o))
    else $error("no-op mishandled");
  AST_NOP_KEEPS_CFG: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    cmd.nop |=> $stable(pixel_format_o) && $stable(scroll_height_o))
    else $error("no-op changed a setting");

  // Soft clear must land every default except power_down_o in the cycle after the strobe
  AST_SOFT_PULSE: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    cmd.soft_clear |=> soft_clear_o)
    else $error("soft clear pulse missing");
  AST_CLR_FLAGS: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    clr |=> pump_flag_o && panel_flag_o)
    else $error("soft clear left a power flag low");
  AST_CLR_MODES: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    clr |=> !polarity_invert_o && !tear_pulse_en_o && !low_colour_o &&
      full_panel_mode_o)
    else $error("soft clear mode flags wrong");
  AST_CLR_ORIENT: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    clr |=> orient_flags_o == 10'h000 && temp_comp_frame_rate_en_o &&
      temp_comp_voltage_en_o)
    else $error("soft clear orientation flags wrong");
  AST_CLR_WINDOW: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    clr |=> column_window_start_o == LRP_WIN_START_RST &&
      column_window_end_o == LRP_WIN_END_RST && row_window_start_o == LRP_WIN_START_RST &&
      row_window_end_o == LRP_WIN_END_RST)
    else $error("soft clear window wrong");
  AST_CLR_AREAS: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    clr |=> partial_area_start_o == LRP_PART_START_RST &&
      partial_area_end_o == LRP_PART_END_RST && top_fixed_rows_o == LRP_FIXED_RST &&
      bottom_fixed_rows_o == LRP_FIXED_RST && scroll_entry_point_o == LRP_SEP_RST)
    else $error("soft clear scroll areas wrong");
  AST_CLR_PIXFMT: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    clr |=> pixel_format_o == LRP_PIXFMT_RST)
    else $error("soft clear pixel format wrong");
  AST_CLR_MAKER: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    clr |=> use_maker_defaults_o)
    else $error("soft clear maker default flag wrong");
  AST_LOCK_KEEPS_MAKER: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    lock_maker_defaults_i |=> use_maker_defaults_o)
    else $error("maker defaults dropped while locked");
  AST_CLR_CAL: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    clr |=> !calibration_flag_o && !otp_prog_voltage_en_o &&
      otp_row_select_o == LRP_OTP_ROW_RST)
    else $error("soft clear calibration state wrong");
  AST_PROG_NEEDS_CAL: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    otp_prog_voltage_en_o |-> $past(calibration_flag_o))
    else $error("programming voltage outside calibration");

  // Power sequencing
  AST_CLR_DOWN: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    clr |=> ##1 power_down_o && !panel_drive_o)
    else $error("soft clear did not enter power-down");
  AST_DOWN_GROUNDS: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    state == LRP_PWR_DOWN |=> !panel_drive_o && !supply_out_en_o)
    else $error("outputs driven in power-down");
  AST_DOWN_KEEPS_FLAGS: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (sleep_in_i && !clr && !cmd.pump_off && !cmd.pump_on && !panel_off_cmd_i &&
      !panel_on_cmd_i) |=> $stable(pump_flag_o) && $stable(panel_flag_o))
    else $error("power-down changed stored flags");
  AST_WAKE_RAMP: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (state == LRP_PWR_DOWN && sleep_out_i && !sleep_in_i && !clr) |=>
      state == LRP_PWR_RAMP)
    else $error("wake did not start supply ramp");
  AST_RAMP_DARK: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    state != LRP_PWR_RUN |=> !panel_drive_o)
    else $error("panel driven before supply runs");
  AST_READY_OFF: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    !pump_flag_o |=> !status_ready_o)
    else $error("ready bit set with booster off");
endmodule // lrp_power_ctrl

// file: inc/lrp_pkg.sv
// Constants shared by the reset and power command slice.
// Assumes command bytes arrive already deserialised, one strobe per byte.
package lrp_pkg;
  localparam logic [7:0] LRP_CMD_NOP = 8'h00;
  localparam logic [7:0] LRP_CMD_SOFT_CLEAR = 8'h01;
  localparam logic [7:0] LRP_CMD_PUMP_OFF = 8'h02;
  localparam logic [7:0] LRP_CMD_PUMP_ON = 8'h03;
  localparam logic [7:0] LRP_WIN_START_RST = 8'h02;
  localparam logic [7:0] LRP_WIN_END_RST = 8'h81;
  localparam logic [7:0] LRP_PART_START_RST = 8'h00;
  localparam logic [7:0] LRP_PART_END_RST = 8'h1F;
  localparam logic [7:0] LRP_FIXED_RST = 8'h00;
  localparam logic [7:0] LRP_SCROLL_RST = 8'h82;
  localparam logic [7:0] LRP_SEP_RST = 8'h00;
  localparam logic [2:0] LRP_PIXFMT_RST = 3'h3;
  localparam logic [2:0] LRP_OTP_ROW_RST = 3'h0;
  localparam int LRP_STABLE_CYCLES = 4;
  typedef enum logic [1:0] {LRP_PWR_DOWN, LRP_PWR_RAMP, LRP_PWR_RUN} lrp_pwr_e;
endpackage

// file: inc/lrp_cmd_if.sv
// Decoded command strobes passed from decoder to the state holder.
// Assumes one clock domain.
interface lrp_cmd_if;
  logic nop;
  logic soft_clear;
  logic pump_off;
  logic pump_on;
  modport dec (output nop, output soft_clear, output pump_off, output pump_on);
  modport use_side (input nop, input soft_clear, input pump_off, input pump_on);
endinterface

// file: verilog/lrp_decode.sv
// Command byte decoder for the reset and power commands.
// Assumes byte strobe and select come from same-clock logic.
module lrp_decode (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic byte_valid_i,
  input wire logic cmd_sel_n_i,
  input wire logic [7:0] byte_i,
  lrp_cmd_if.dec cmd
);
  import lrp_pkg::*;
  logic is_cmd;
  assign is_cmd = byte_valid_i && !cmd_sel_n_i;
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      cmd.nop <= 1'b0;
      cmd.soft_clear <= 1'b0;
      cmd.pump_off <= 1'b0;
      cmd.pump_on <= 1'b0;
    end else begin
      cmd.nop <= is_cmd && byte_i == LRP_CMD_NOP;
      cmd.soft_clear <= is_cmd && byte_i == LRP_CMD_SOFT_CLEAR;
      cmd.pump_off <= is_cmd && byte_i == LRP_CMD_PUMP_OFF;
      cmd.pump_on <= is_cmd && byte_i == LRP_CMD_PUMP_ON;
    end
  end
  AST_DATA_NOT_CMD: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (byte_valid_i && cmd_sel_n_i) |=>
      !(cmd.nop || cmd.soft_clear || cmd.pump_on || cmd.pump_off))
    else $error("data byte decoded as command");
endmodule // lrp_decode

// file: tb/lrp_host_model.sv
// Host side of the command byte path: sends one byte per call.
// Assumes the bench calls send from a single process only.
module lrp_host_model (
  input wire logic clk_i,
  output logic byte_valid_o,
  output logic cmd_sel_n_o,
  output logic [7:0] byte_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    byte_valid_o = 1'b0;
    cmd_sel_n_o = 1'b1;
    byte_o = 8'hA5;
  end
  // Idle bus shows inverted last value so stale data never passes
  task automatic send(input logic [7:0] b, input logic sel_n);
    @(posedge clk_i);
    #1;
    byte_valid_o = 1'b1;
    cmd_sel_n_o = sel_n;
    byte_o = b;
    @(posedge clk_i);
    #1;
    byte_valid_o = 1'b0;
    cmd_sel_n_o = 1'b1;
    byte_o = ~b;
  endtask
endmodule // lrp_host_model

// file: tb/lrp_power_ctrl_bench.sv
// Self-checking bench for the reset and power command slice.
// Assumes the host model drives the byte path; supply generator modelled inline.
module lrp_power_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import lrp_pkg::*;
  logic clk_sys_i, reset_i, byte_valid, cmd_sel_n, supply_ready, lock, otp_req;
  logic [7:0] byte_d;
  logic [4:0] pl;
  logic panel_drive, power_down, pump_en, status_ready, pump_flag, panel_flag;
  int failures = 0;
  int tests_run = 0;
  // Row: byte, select_n, expected no-op pulse, expected booster flag, soft clear pulse
  logic [11:0] rows [7] = '{12'h006, 12'h020, 12'h038, 12'h008, 12'h040, 12'h013,
    12'h032};
  lrp_host_model u_host (.clk_i(clk_sys_i), .byte_valid_o(byte_valid),
    .cmd_sel_n_o(cmd_sel_n), .byte_o(byte_d));
  lrp_power_ctrl u_dut (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .byte_valid_i(byte_valid),
    .cmd_sel_n_i(cmd_sel_n), .byte_i(byte_d), .sleep_in_i(pl[4]), .sleep_out_i(pl[3]),
    .panel_on_cmd_i(pl[2]), .panel_off_cmd_i(pl[1]), .supply_ready_i(supply_ready),
    .lock_maker_defaults_i(lock), .calib_enter_i(pl[0]), .otp_prog_req_i(otp_req),
    .transfer_end_o(), .soft_clear_o(), .iface_drive_en_o(), .power_down_o(power_down),
    .pump_enable_o(pump_en), .supply_out_en_o(), .panel_drive_o(panel_drive),
    .status_ready_o(status_ready), .pump_flag_o(pump_flag), .panel_flag_o(panel_flag),
    .polarity_invert_o(), .tear_pulse_en_o(), .low_colour_o(), .full_panel_mode_o(),
    .orient_flags_o(), .temp_comp_frame_rate_en_o(), .temp_comp_voltage_en_o(),
    .column_window_start_o(), .column_window_end_o(), .row_window_start_o(),
    .row_window_end_o(), .partial_area_start_o(), .partial_area_end_o(),
    .top_fixed_rows_o(), .bottom_fixed_rows_o(), .scroll_height_o(),
    .scroll_entry_point_o(), .pixel_format_o(), .use_maker_defaults_o(),
    .calibration_flag_o(), .otp_prog_voltage_en_o(), .otp_row_select_o());
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  // Supply generator: ready one cycle after the pump runs
  always @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) supply_ready <= 1'b0;
    else supply_ready <= pump_en;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  task automatic pulse(input logic [4:0] m);
    @(posedge clk_sys_i);
    #1;
    pl = m;
    tick(1);
    pl = 5'h00;
  endtask
  task automatic defaults(input logic pf);
    chk({power_down, panel_drive, pump_en, u_dut.supply_out_en_o}, 16'h0008);
    chk(u_dut.iface_drive_en_o, 16'h0000);
    chk({pump_flag, panel_flag, u_dut.polarity_invert_o, u_dut.tear_pulse_en_o,
      u_dut.low_colour_o, u_dut.full_panel_mode_o}, {pf, 5'h11});
    chk({u_dut.orient_flags_o, u_dut.temp_comp_frame_rate_en_o,
      u_dut.temp_comp_voltage_en_o}, 16'h0003);
    chk({u_dut.column_window_start_o, u_dut.column_window_end_o}, 16'h0281);
    chk({u_dut.row_window_start_o, u_dut.row_window_end_o}, 16'h0281);
    chk({u_dut.partial_area_start_o, u_dut.partial_area_end_o}, 16'h001F);
    chk({u_dut.top_fixed_rows_o, u_dut.bottom_fixed_rows_o}, 16'h0000);
    chk({u_dut.scroll_height_o, u_dut.scroll_entry_point_o}, 16'h8200);
    chk({u_dut.pixel_format_o, u_dut.use_maker_defaults_o, u_dut.calibration_flag_o,
      u_dut.otp_prog_voltage_en_o, u_dut.otp_row_select_o}, 16'h00E0);
  endtask
  task automatic wake();
    pulse(5'h08);
    for (int i = 0; i < 40 && panel_drive !== 1'b1; i++) begin
      if (supply_ready !== 1'b1) chk(panel_drive, 16'h0000);
      tick(1);
    end
    chk({power_down, panel_drive, status_ready}, 16'h0003);
  endtask
  task automatic wrap_up();
    if (failures == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #100us;
    failures++;
    wrap_up();
  end
  initial begin
    reset_i = 1'b1;
    pl = 5'h00;
    lock = 1'b0;
    otp_req = 1'b0;
    tick(8);
    reset_i = 1'b0;
    defaults(1'b1);
    foreach (rows[i]) begin
      u_host.send(rows[i][11:4], rows[i][3]);
      tick(1);
      chk(u_dut.transfer_end_o, {15'h0000, rows[i][2]});
      chk(u_dut.soft_clear_o, {15'h0000, rows[i][0]});
      tick(1);
      chk(pump_flag, {15'h0000, rows[i][1]});
      chk(pump_en, 16'h0000);
    end
    wake();
    u_host.send(8'h02, 1'b0);
    tick(2);
    chk({pump_en, u_dut.supply_out_en_o}, 16'h0000);
    tick(5);
    chk(status_ready, 16'h0000);
    u_host.send(8'h03, 1'b0);
    tick(2);
    chk(pump_en, 16'h0001);
    wake();
    pulse(5'h10);
    tick(3);
    chk({power_down, pump_en, panel_drive, pump_flag, panel_flag}, 16'h0013);
    pulse(5'h02);
    tick(2);
    chk(panel_flag, 16'h0000);
    u_host.send(8'h01, 1'b0);
    u_host.send(8'h02, 1'b0);
    tick(4);
    defaults(1'b0);
    lock = 1'b1;
    otp_req = 1'b1;
    pulse(5'h01);
    tick(3);
    chk({u_dut.calibration_flag_o, u_dut.otp_prog_voltage_en_o}, 16'h0000);
    lock = 1'b0;
    pulse(5'h01);
    tick(3);
    chk({u_dut.calibration_flag_o, u_dut.otp_prog_voltage_en_o}, 16'h0003);
    otp_req = 1'b0;
    tick(16);
    reset_i = 1'b1;
    tick(2);
    reset_i = 1'b0;
    tick(1);
    defaults(1'b1);
    wrap_up();
  end
endmodule // lrp_power_ctrl_bench
